/* File: rtl/mac_wake_defines.vh */
`ifndef MAC_WAKE_DEFINES_VH
`define MAC_WAKE_DEFINES_VH

// ***********************************************************
// Register map
// ***********************************************************
`define ADDR_W 12
`define DATA_W 32
`define OFS_WAKE 12'h12c
`define OFS_CSUM 12'h130
`define OFS_IRQ_STS 12'h140
`define OFS_IRQ_MSK 12'h144
`define OFS_WAKE_AUX 12'h148

// One-hot register selects
`define SEL_W 5
`define SEL_NONE 5'h00
`define SEL_WAKE 5'h01
`define SEL_CSUM 5'h02
`define SEL_IRQ_STS 5'h04
`define SEL_IRQ_MSK 5'h08
`define SEL_WAKE_AUX 5'h10
`define IDX_WAKE 0
`define IDX_CSUM 1
`define IDX_IRQ_STS 2
`define IDX_IRQ_MSK 3
`define IDX_WAKE_AUX 4

// ***********************************************************
// Field layout
// ***********************************************************
`define WK_BROADCAST_WAKE_EN 0
`define WK_SYNC_EN 1
`define WK_FILT_EN 2
`define WK_STA_EN 3
`define WK_EN_N 4
`define WK_EN_MSB 3
`define WK_FLAG_LSB 4
`define WK_FLAG_MSB 6
`define WK_FLAG_N 3
`define CS_RX_EN 0
`define CS_RX_MODE 1
`define CS_TX_EN 16
`define IRQ_N 4
`define IRQ_MSB 3
`define AUX_RES_CLR 0

// ***********************************************************
// Reset values and constants
// ***********************************************************
`define RST_WAKE_EN 4'h0
`define RST_IRQ_MSK 4'h0
`define RST_BIT 1'b0
`define ZERO32 32'h00000000
`define CSUM_START_W 8
`define CSUM_FIXED_START_BYTES 8'h0e
`define CSUM_L3_START_BYTES 8'h00

`endif

/* File: rtl/sticky_flag.v */
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// Sticky event flag with clear
// ***********************************************************
module sticky_flag
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Control
   input wire set_evt,
   input wire clear_req,
   // State
   output wire flag
);

reg flag_ff;
wire nxt_flag;

// Set beats a clear in the same cycle
assign nxt_flag = set_evt | (flag_ff & ~clear_req);

// Flag storage
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      flag_ff <= 1'b0;
   else
      flag_ff <= nxt_flag;
end

assign flag = flag_ff;

endmodule
`default_nettype wire

/* File: rtl/mac_wake_and_checksum_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "mac_wake_defines.vh"

// ***********************************************************
// Wakeup and checksum offload control registers
// ***********************************************************
module mac_wake_and_checksum_ctrl
(
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`ADDR_W-1:0] paddr,
   input wire [`DATA_W-1:0] pwdata,
   input wire [3:0] pstrb,
   output wire [`DATA_W-1:0] prdata,
   output wire pready,
   output wire pslverr,
   // Receive event pulses from the MAC
   input wire rx_filter_frame_match,
   input wire rx_sync_pattern_packet,
   input wire rx_broadcast_frame,
   input wire rx_station_addr_match,
   input wire resume_done,
   // Wakeup controls
   output wire station_address_wake_en,
   output wire filter_wake_en,
   output wire sync_pattern_wake_en,
   output wire broadcast_wake_en,
   output wire remote_wakeup_mode,
   output wire wake_request,
   // Checksum engine controls
   output wire tx_checksum_engine_en,
   output wire rx_checksum_engine_en,
   output wire rx_checksum_start_mode,
   output wire [`CSUM_START_W-1:0] rx_checksum_start_offset,
   // Interrupt
   output wire irq
);

// ***********************************************************
// Address decode
// ***********************************************************
function [`SEL_W-1:0] reg_select;
   input [`ADDR_W-1:0] addr;
   begin
      reg_select = `SEL_NONE;
      case (addr)
         `OFS_WAKE: reg_select = `SEL_WAKE;
         `OFS_CSUM: reg_select = `SEL_CSUM;
         `OFS_IRQ_STS: reg_select = `SEL_IRQ_STS;
         `OFS_IRQ_MSK: reg_select = `SEL_IRQ_MSK;
         `OFS_WAKE_AUX: reg_select = `SEL_WAKE_AUX;
         default: reg_select = `SEL_NONE;
      endcase
   end
endfunction

// ***********************************************************
// Declarations
// ***********************************************************
reg pready_ff;
reg pslverr_ff;
reg [`DATA_W-1:0] prdata_ff;
reg [`WK_EN_MSB:0] wake_en_ff;
reg [`WK_EN_MSB:0] nxt_wake_en;
reg tx_en_ff;
reg nxt_tx_en;
reg rx_en_ff;
reg nxt_rx_en;
reg rx_mode_ff;
reg nxt_rx_mode;
reg [`IRQ_MSB:0] irq_msk_ff;
reg [`IRQ_MSB:0] nxt_irq_msk;
reg res_clr_ff;
reg nxt_res_clr;
reg wake_req_ff;
reg wake_mode_ff;
reg irq_ff;
reg [`CSUM_START_W-1:0] csum_ofs_ff;
reg [`CSUM_START_W-1:0] nxt_csum_ofs;
reg [`DATA_W-1:0] rd_word;

wire setup_ph;
wire wr_fire;
wire [`SEL_W-1:0] sel_setup;
wire [`SEL_W-1:0] sel_acc;
wire [`DATA_W-1:0] wmask;
wire [`DATA_W-1:0] wr_data;
wire [`WK_FLAG_N-1:0] wake_set;
wire [`WK_FLAG_N-1:0] wake_clr;
wire [`WK_FLAG_N-1:0] wake_flag;
wire [`IRQ_N-1:0] irq_set;
wire [`IRQ_N-1:0] irq_clr;
wire [`IRQ_N-1:0] irq_sts;
wire nxt_wake_req;
wire nxt_wake_mode;
wire nxt_irq;

// ***********************************************************
// Bus phase and write qualifiers
// ***********************************************************
// Setup phase, and completion of a write access
assign setup_ph = psel & ~penable;
assign wr_fire = psel & penable & pready_ff & pwrite;
assign sel_setup = reg_select(paddr);
assign sel_acc = reg_select(paddr);

// Byte strobes expanded to a bit mask
assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                {8{pstrb[1]}}, {8{pstrb[0]}}};
assign wr_data = pwdata & wmask;

// ***********************************************************
// Wakeup status flags
// ***********************************************************
// Broadcast, sync and filter receptions set flags regardless of the enables
assign wake_set[`WK_BROADCAST_WAKE_EN] = rx_broadcast_frame;
assign wake_set[`WK_SYNC_EN] = rx_sync_pattern_packet;
assign wake_set[`WK_FILT_EN] = rx_filter_frame_match;

// Write one to clear, or cleared when a resume completes
assign wake_clr = ({`WK_FLAG_N{wr_fire & sel_acc[`IDX_WAKE]}}
                   & wr_data[`WK_FLAG_MSB:`WK_FLAG_LSB])
                | {`WK_FLAG_N{resume_done & res_clr_ff}};

genvar gi;
generate
   for (gi = 0; gi < `WK_FLAG_N; gi = gi + 1)
   begin : g_wake_flag
      // Set wins over any clear
      sticky_flag u_flag
      (
         .pclk(pclk),
         .presetn(presetn),
         .set_evt(wake_set[gi]),
         .clear_req(wake_clr[gi]),
         .flag(wake_flag[gi])
      );
   end
endgenerate

// ***********************************************************
// Interrupt status flags
// ***********************************************************
// One bit per reception kind, station match on the top bit
assign irq_set = {rx_station_addr_match, rx_filter_frame_match,
                  rx_sync_pattern_packet, rx_broadcast_frame};
assign irq_clr = {`IRQ_N{wr_fire & sel_acc[`IDX_IRQ_STS]}}
               & wr_data[`IRQ_MSB:0];

generate
   for (gi = 0; gi < `IRQ_N; gi = gi + 1)
   begin : g_irq_flag
      sticky_flag u_flag
      (
         .pclk(pclk),
         .presetn(presetn),
         .set_evt(irq_set[gi]),
         .clear_req(irq_clr[gi]),
         .flag(irq_sts[gi])
      );
   end
endgenerate

// Level interrupt while any unmasked bit is set
assign nxt_irq = |(irq_sts & irq_msk_ff);

// ***********************************************************
// Control register next values
// ***********************************************************
// Masked update of writable fields on a completed write
always @*
begin
   nxt_wake_en = wake_en_ff;
   nxt_tx_en = tx_en_ff;
   nxt_rx_en = rx_en_ff;
   nxt_rx_mode = rx_mode_ff;
   nxt_irq_msk = irq_msk_ff;
   nxt_res_clr = res_clr_ff;
   if (wr_fire && sel_acc[`IDX_WAKE])
   begin
      nxt_wake_en = (wake_en_ff & ~wmask[`WK_EN_MSB:0])
                  | wr_data[`WK_EN_MSB:0];
   end
   if (wr_fire && sel_acc[`IDX_CSUM])
   begin
      // Caller keeps the paths idle while these change
      if (wmask[`CS_TX_EN])
         nxt_tx_en = pwdata[`CS_TX_EN];
      if (wmask[`CS_RX_EN])
         nxt_rx_en = pwdata[`CS_RX_EN];
      if (wmask[`CS_RX_MODE])
         nxt_rx_mode = pwdata[`CS_RX_MODE];
   end
   if (wr_fire && sel_acc[`IDX_IRQ_MSK])
   begin
      nxt_irq_msk = (irq_msk_ff & ~wmask[`IRQ_MSB:0])
                  | wr_data[`IRQ_MSB:0];
   end
   if (wr_fire && sel_acc[`IDX_WAKE_AUX] && wmask[`AUX_RES_CLR])
      nxt_res_clr = pwdata[`AUX_RES_CLR];
end

// Start offset handed to the receive checksum engine
always @*
begin
   if (nxt_rx_mode)
      nxt_csum_ofs = `CSUM_L3_START_BYTES;
   else
      nxt_csum_ofs = `CSUM_FIXED_START_BYTES;
end

// ***********************************************************
// Wakeup decisions
// ***********************************************************
// Wake when an armed source sees its reception
assign nxt_wake_req =
     (wake_en_ff[`WK_STA_EN] & rx_station_addr_match)
   | (wake_en_ff[`WK_FILT_EN] & rx_filter_frame_match)
   | (wake_en_ff[`WK_SYNC_EN] & rx_sync_pattern_packet)
   | (wake_en_ff[`WK_BROADCAST_WAKE_EN] & rx_broadcast_frame);

// Remote wakeup mode from the frame-based enables
assign nxt_wake_mode = nxt_wake_en[`WK_STA_EN]
                     | nxt_wake_en[`WK_FILT_EN]
                     | nxt_wake_en[`WK_BROADCAST_WAKE_EN];

// ***********************************************************
// Register read mux
// ***********************************************************
always @*
begin
   rd_word = `ZERO32;
   case (sel_setup)
      `SEL_WAKE:
      begin
         rd_word[`WK_FLAG_MSB:`WK_FLAG_LSB] = wake_flag;
         rd_word[`WK_EN_MSB:0] = wake_en_ff;
      end
      `SEL_CSUM:
      begin
         rd_word[`CS_TX_EN] = tx_en_ff;
         rd_word[`CS_RX_MODE] = rx_mode_ff;
         rd_word[`CS_RX_EN] = rx_en_ff;
      end
      `SEL_IRQ_STS: rd_word[`IRQ_MSB:0] = irq_sts;
      `SEL_IRQ_MSK: rd_word[`IRQ_MSB:0] = irq_msk_ff;
      `SEL_WAKE_AUX: rd_word[`AUX_RES_CLR] = res_clr_ff;
      default: rd_word = `ZERO32;
   endcase
end

// ***********************************************************
// APB answer
// ***********************************************************
// Answer is prepared in setup, dropped after completion
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `ZERO32;
   end
   else if (setup_ph)
   begin
      pready_ff <= 1'b1;
      pslverr_ff <= (sel_setup == `SEL_NONE);
      prdata_ff <= pwrite ? `ZERO32 : rd_word;
   end
   else if (psel && penable && pready_ff)
   begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `ZERO32;
   end
end

// ***********************************************************
// Control and output registers
// ***********************************************************
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      wake_en_ff <= `RST_WAKE_EN;
      tx_en_ff <= `RST_BIT;
      rx_en_ff <= `RST_BIT;
      rx_mode_ff <= `RST_BIT;
      irq_msk_ff <= `RST_IRQ_MSK;
      res_clr_ff <= `RST_BIT;
      csum_ofs_ff <= `CSUM_FIXED_START_BYTES;
      wake_req_ff <= 1'b0;
      wake_mode_ff <= 1'b0;
      irq_ff <= 1'b0;
   end
   else
   begin
      wake_en_ff <= nxt_wake_en;
      tx_en_ff <= nxt_tx_en;
      rx_en_ff <= nxt_rx_en;
      rx_mode_ff <= nxt_rx_mode;
      irq_msk_ff <= nxt_irq_msk;
      res_clr_ff <= nxt_res_clr;
      csum_ofs_ff <= nxt_csum_ofs;
      wake_req_ff <= nxt_wake_req;
      wake_mode_ff <= nxt_wake_mode;
      irq_ff <= nxt_irq;
   end
end

// ***********************************************************
// Output wiring
// ***********************************************************
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign station_address_wake_en = wake_en_ff[`WK_STA_EN];
assign filter_wake_en = wake_en_ff[`WK_FILT_EN];
assign sync_pattern_wake_en = wake_en_ff[`WK_SYNC_EN];
assign broadcast_wake_en = wake_en_ff[`WK_BROADCAST_WAKE_EN];
assign remote_wakeup_mode = wake_mode_ff;
assign wake_request = wake_req_ff;
assign tx_checksum_engine_en = tx_en_ff;
assign rx_checksum_engine_en = rx_en_ff;
assign rx_checksum_start_mode = rx_mode_ff;
assign rx_checksum_start_offset = csum_ofs_ff;
assign irq = irq_ff;

endmodule
`default_nettype wire

/* File: test/mac_wake_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_wake_defines.vh"

// ***********************************************************
// Port checker for the wakeup and checksum registers
// ***********************************************************
module mac_wake_ctrl_sva
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic pready,
   // Receive events
   input wire logic rx_filter_frame_match,
   input wire logic rx_sync_pattern_packet,
   input wire logic rx_broadcast_frame,
   input wire logic rx_station_addr_match,
   // Controls
   input wire logic station_address_wake_en,
   input wire logic filter_wake_en,
   input wire logic sync_pattern_wake_en,
   input wire logic broadcast_wake_en,
   input wire logic remote_wakeup_mode,
   input wire logic wake_request,
   input wire logic tx_checksum_engine_en,
   input wire logic rx_checksum_engine_en,
   input wire logic rx_checksum_start_mode,
   input wire logic [`CSUM_START_W-1:0] rx_checksum_start_offset
);
   // Armed event and checksum write strobe
   wire armed = (rx_broadcast_frame && broadcast_wake_en) ||
      (rx_sync_pattern_packet && sync_pattern_wake_en) ||
      (rx_filter_frame_match && filter_wake_en) ||
      (rx_station_addr_match && station_address_wake_en);
   wire csum_wr = psel && penable && pready && pwrite &&
      (paddr == `OFS_CSUM);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_armed_wake: assert property (
      armed |=> wake_request) else $error("wake request missing");
   a_no_stray: assert property (
      !armed |=> !wake_request) else $error("stray wake request");
   a_mode_level: assert property (
      remote_wakeup_mode == (station_address_wake_en ||
      filter_wake_en || broadcast_wake_en))
      else $error("wakeup mode level wrong");
   a_offset_mode: assert property (
      rx_checksum_start_offset == (rx_checksum_start_mode ?
      `CSUM_L3_START_BYTES : `CSUM_FIXED_START_BYTES))
      else $error("start offset wrong");
   a_tx_hold: assert property (
      !$stable(tx_checksum_engine_en) |-> $past(csum_wr))
      else $error("tx enable moved without write");
   a_rx_hold: assert property (
      !$stable(rx_checksum_engine_en) |-> $past(csum_wr))
      else $error("rx enable moved without write");
   a_mode_hold: assert property (
      !$stable(rx_checksum_start_mode) |-> $past(csum_wr))
      else $error("rx mode moved without write");
   a_ready_pulse: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("ready not one access cycle");
endmodule

bind mac_wake_and_checksum_ctrl mac_wake_ctrl_sva mac_wake_ctrl_sva_i
(
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
   .rx_filter_frame_match, .rx_sync_pattern_packet,
   .rx_broadcast_frame, .rx_station_addr_match,
   .station_address_wake_en, .filter_wake_en,
   .sync_pattern_wake_en, .broadcast_wake_en, .remote_wakeup_mode,
   .wake_request, .tx_checksum_engine_en, .rx_checksum_engine_en,
   .rx_checksum_start_mode, .rx_checksum_start_offset
);

`default_nettype wire

/* File: test/mac_wake_and_checksum_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mac_wake_defines.vh"

// ***********************************************************
// Register level bench
// ***********************************************************
module mac_wake_and_checksum_ctrl_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`ADDR_W-1:0] paddr = 12'h000;
   logic [`DATA_W-1:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic [4:0] ev = 5'h00;
   wire [`DATA_W-1:0] prdata;
   wire pready, pslverr, remote_wakeup_mode, wake_request, irq;
   wire station_address_wake_en, filter_wake_en;
   wire sync_pattern_wake_en, broadcast_wake_en;
   wire tx_checksum_engine_en, rx_checksum_engine_en;
   wire rx_checksum_start_mode;
   wire [`CSUM_START_W-1:0] rx_checksum_start_offset;
   int err_total = 0;
   int samples_checked = 0;
   logic [31:0] rd, ex;
   logic er, wr;

   always #25 pclk = ~pclk;

   mac_wake_and_checksum_ctrl mac_wake_and_checksum_ctrl_i
   (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr,
      .rx_broadcast_frame(ev[0]), .rx_sync_pattern_packet(ev[1]),
      .rx_filter_frame_match(ev[2]), .rx_station_addr_match(ev[3]),
      .resume_done(ev[4]), .station_address_wake_en, .filter_wake_en,
      .sync_pattern_wake_en, .broadcast_wake_en, .remote_wakeup_mode,
      .wake_request, .tx_checksum_engine_en, .rx_checksum_engine_en,
      .rx_checksum_start_mode, .rx_checksum_start_offset, .irq
   );

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Compare seen against expected
   task automatic chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask

   // One APB transfer, pready sampled at rising edges with a bound
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge pclk);
      end
      if (pready !== 1'b1)
      begin
         $display("[FAIL] pready expected 1 seen %b", pready);
         err_total++;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // One-cycle event pulse, then sample the wake request
   task automatic pulse(input int i, output logic w);
      @(posedge pclk);
      ev <= 5'h01 << i;
      @(posedge pclk);
      ev <= 5'h00;
      @(negedge pclk);
      w = wake_request;
   endtask

   // Main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("offset", {24'h0, rx_checksum_start_offset}, 32'h0e);
      apb(0, `OFS_CSUM, 0, rd, er);
      chk("csum rst", rd, 32'h0);
      chk("mapped okay", er, 1'b0);
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("wake rst", rd, 32'h0);
      apb(1, `OFS_WAKE, 32'h0f, rd, er);
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("wake en", rd, 32'h0f);
      rd = {28'h0, station_address_wake_en, filter_wake_en,
         sync_pattern_wake_en, broadcast_wake_en};
      chk("en pins", rd, 32'h0f);
      chk("mode on", remote_wakeup_mode, 1'b1);
      ex = 32'h0f;
      for (int i = 0; i < 4; i++)
      begin
         pulse(i, wr);
         chk("wake req", wr, 1'b1);
         if (i < 3)
            ex = ex | (32'h10 << i);
         apb(0, `OFS_WAKE, 0, rd, er);
         chk("wake flags", rd, ex);
      end
      apb(1, `OFS_WAKE, 32'h2f, rd, er);
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("w1c", rd, 32'h5f);
      pulse(4, wr);
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("resume off", rd, 32'h5f);
      apb(1, `OFS_WAKE_AUX, 1, rd, er);
      pulse(4, wr);
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("resume on", rd, 32'h0f);
      pulse(0, wr);
      fork
         apb(1, `OFS_WAKE, 32'h1f, rd, er);
         begin
            repeat (2) @(posedge pclk);
            ev <= 5'h01;
            @(posedge pclk);
            ev <= 5'h00;
         end
      join
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("set wins", rd, 32'h1f);
      pstrb <= 4'h0;
      apb(1, `OFS_WAKE, 32'h7f, rd, er);
      pstrb <= 4'hf;
      apb(0, `OFS_WAKE, 0, rd, er);
      chk("no lanes", rd, 32'h1f);
      apb(1, `OFS_IRQ_MSK, 1, rd, er);
      @(posedge pclk);
      @(negedge pclk);
      chk("irq on", irq, 1'b1);
      apb(1, `OFS_IRQ_STS, 32'hf, rd, er);
      @(posedge pclk);
      @(negedge pclk);
      chk("irq clr", irq, 1'b0);
      pulse(1, wr);
      @(posedge pclk);
      @(negedge pclk);
      chk("irq masked", irq, 1'b0);
      apb(0, `OFS_IRQ_STS, 0, rd, er);
      chk("irq sts", rd, 32'h2);
      apb(1, `OFS_WAKE, 32'h02, rd, er);
      pulse(0, wr);
      chk("bcast off", wr, 1'b0);
      pulse(1, wr);
      chk("sync on", wr, 1'b1);
      chk("mode", remote_wakeup_mode, 1'b0);
      apb(1, `OFS_CSUM, 32'hffffffff, rd, er); // paths idle
      apb(0, `OFS_CSUM, 0, rd, er);
      chk("csum all", rd, 32'h00010003);
      chk("offset l3", {24'h0, rx_checksum_start_offset}, 32'h0);
      chk("mode pin", rx_checksum_start_mode, 1'b1);
      apb(1, `OFS_CSUM, 32'h1, rd, er); // paths idle
      @(negedge pclk);
      chk("tx off", tx_checksum_engine_en, 1'b0);
      chk("rx on", rx_checksum_engine_en, 1'b1);
      chk("offset", {24'h0, rx_checksum_start_offset}, 32'h0e);
      apb(0, 12'h200, 0, rd, er);
      chk("unmapped err", er, 1'b1);
      chk("unmapped rd", rd, 32'h0);
      tally_and_finish();
   end
endmodule

`default_nettype wire
